/* pkg/sea_defs.svh */
// Constants of the serial EEPROM access and protection block
`ifndef SEA_DEFS_SVH
`define SEA_DEFS_SVH
// Select byte type field
`define SEA_TYPE_MEM 4'ha
`define SEA_TYPE_CMD 4'h6
// Select address codes of the command type
`define SEA_CODE_BLK0 3'h1
`define SEA_CODE_BLK1 3'h4
`define SEA_CODE_BLK2 3'h5
`define SEA_CODE_BLK3 3'h0
`define SEA_CODE_CLEAR 3'h3
`define SEA_CODE_HALF0 3'h6
`define SEA_CODE_HALF1 3'h7
// Bit counter values of the acknowledge slot
`define SEA_ACK_BIT 4'h8
`define SEA_ACK_END 4'h9
// Timing
`define SEA_CLK_PERIOD_NS 20
`define SEA_T_WRITE_NS 5000000
`endif

/* pkg/sea_pkg.sv */
// Types of the serial EEPROM access and protection block
`default_nettype none
package sea_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_ADDR, ST_WDATA, ST_RDATA, ST_CMD} sea_state_t;
	typedef enum logic [1:0] {OP_NONE, OP_MEM, OP_SET, OP_CLR} sea_op_t;
	typedef struct packed {
		logic [8:0] loc;
		logic [7:0] data;
	} sea_wr_t;
	typedef struct packed {
		logic scl;
		logic sda;
		logic hv;
		logic [2:0] logical_select_address;
	} sea_pins_t;
endpackage
`default_nettype wire

/* hdl/sea_eeprom.sv */
// Two-wire EEPROM slave with block write protection and half select
//
// Behaviour
// - Write select is acked, then one address byte is acked, then data follows.
// - Programming starts only on a stop right after a data acknowledge.
// - During programming the memory section ignores the bus entirely.
// - Counter advances per written byte, not for protected targets.
// - Protected data byte gets nack and no change; unprotected gets ack.
// - Page write holds 1 to 16 bytes, programmed in one cycle.
// - Select during programming is nacked; master polls until acked.
// - Reads ignore write protection.
// - Random read: address write, repeated start, read select, nack, stop.
// - Read without address returns byte at counter, then increments.
// - Master ack yields next byte; nack plus stop ends the stream.
// - Sequential read counter wraps from last location to 0x00.
// - Missing master ack after a read byte sends the device idle.
// - Four blocks: half and address bit 7 select the block.
// - Protection bits survive power loss and resets.
// - Set protects one named block; clear unprotects all four.
// - Query acks command only if unprotected; later bytes never acked.
// - Set on protected block: all nack, no cycle; else ack and program.
// - Half query acks for half 0, nacks for half 1.
// - Half select commands choose active half; reset forces half 0.
// - Type 1010 reaches memory, type 0110 reaches commands.
// - Commands ignore the select address bits.
// - Set and clear need the high-voltage select pin.
`default_nettype none
`include "sea_defs.svh"
module sea_eeprom #(
	parameter int T_WRITE_CYC = `SEA_T_WRITE_NS / `SEA_CLK_PERIOD_NS
)(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Bus and strap pins, asynchronous
	input wire sea_pkg::sea_pins_t pins,
	// Open-drain data line
	output logic sda_out,
	output logic sda_oe_n,
	// Status
	output logic prog_busy,
	output logic active_half_index
);
	import sea_pkg::*;

	function automatic logic [2:0] code_blk(input logic [2:0] c);
		unique case (c)
			`SEA_CODE_BLK0: code_blk = 3'h4;
			`SEA_CODE_BLK1: code_blk = 3'h5;
			`SEA_CODE_BLK2: code_blk = 3'h6;
			`SEA_CODE_BLK3: code_blk = 3'h7;
			default: code_blk = 3'h0;
		endcase
	endfunction

	sea_pins_t s1_r, s2_r;
	logic scl_d_r, sda_d_r;
	always_ff @(posedge clk)
	begin
		s1_r <= pins;
		s2_r <= s1_r;
		scl_d_r <= s2_r.scl;
		sda_d_r <= s2_r.sda;
	end
	logic ev_rise, ev_fall, ev_start, ev_stop;
	assign ev_rise = s2_r.scl & ~scl_d_r;
	assign ev_fall = ~s2_r.scl & scl_d_r;
	assign ev_start = s2_r.scl & scl_d_r & ~s2_r.sda & sda_d_r;
	assign ev_stop = s2_r.scl & scl_d_r & s2_r.sda & ~sda_d_r;

	logic [7:0] mem [0:511];
	logic [7:0] pbuf [0:15];
	logic [3:0] prot_r = 4'h0;
	sea_state_t st_r, st_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [7:0] sh_r, sh_nxt, rbyte_r, rbyte_nxt, ptr_r, ptr_nxt;
	logic drv_r, drv_nxt, half_r, half_nxt, slot_r, slot_nxt, fol_r, fol_nxt;
	sea_op_t pend_r, pend_nxt, op_r, op_nxt;
	logic [1:0] pblk_r, pblk_nxt, opblk_r, opblk_nxt;
	logic push_v, push_rdy, arm, drop;
	sea_wr_t push_d;
	logic [2:0] cb;
	logic [8:0] wloc;
	logic prog_r, prog_nxt;

	assign wloc = {half_r, ptr_r};
	assign cb = code_blk(sh_r[3:1]);

	always_comb
	begin
		st_nxt = st_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		rbyte_nxt = rbyte_r;
		ptr_nxt = ptr_r;
		drv_nxt = drv_r;
		half_nxt = half_r;
		slot_nxt = slot_r;
		fol_nxt = fol_r;
		pend_nxt = pend_r;
		pblk_nxt = pblk_r;
		push_v = 1'b0;
		push_d = '0;
		arm = 1'b0;
		drop = 1'b0;
		if (ev_start)
		begin
			st_nxt = ST_SEL;
			bit_nxt = 4'h0;
			drv_nxt = 1'b0;
			slot_nxt = 1'b0;
			pend_nxt = OP_NONE;
			drop = 1'b1;
		end
		else if (ev_stop)
		begin
			if (slot_r && pend_r != OP_NONE)
				arm = 1'b1;
			else
				drop = 1'b1;
			st_nxt = ST_IDLE;
			drv_nxt = 1'b0;
			slot_nxt = 1'b0;
		end
		else if (st_r != ST_IDLE && ev_rise)
		begin
			if (bit_r != `SEA_ACK_BIT)
			begin
				sh_nxt = {sh_r[6:0], s2_r.sda};
				bit_nxt = bit_r + 4'h1;
			end
			else
			begin
				bit_nxt = `SEA_ACK_END;
				if (st_r == ST_RDATA && s2_r.sda)
					st_nxt = ST_IDLE;
			end
		end
		else if (st_r != ST_IDLE && ev_fall)
		begin
			// Stop slot spans the rise after an ack, ends at the next fall
			slot_nxt = 1'b0;
			if (bit_r == `SEA_ACK_BIT)
			begin
				drv_nxt = 1'b0;
				unique case (st_r)
					ST_SEL:
						if (prog_r)
							st_nxt = ST_IDLE;
						else if (sh_r[7:4] == `SEA_TYPE_MEM && sh_r[3:1] == s2_r.logical_select_address)
						begin
							drv_nxt = 1'b1;
							st_nxt = sh_r[0] ? ST_RDATA : ST_ADDR;
						end
						else if (sh_r[7:4] == `SEA_TYPE_CMD)
						begin
							st_nxt = ST_CMD;
							fol_nxt = 1'b0;
							if (!sh_r[0] && sh_r[3:1] == `SEA_CODE_CLEAR && s2_r.hv)
							begin
								drv_nxt = 1'b1;
								fol_nxt = 1'b1;
								pend_nxt = OP_CLR;
							end
							else if (!sh_r[0] && cb[2] && s2_r.hv)
							begin
								drv_nxt = !prot_r[cb[1:0]];
								fol_nxt = !prot_r[cb[1:0]];
								pend_nxt = prot_r[cb[1:0]] ? OP_NONE : OP_SET;
								pblk_nxt = cb[1:0];
							end
							else if (!sh_r[0] && sh_r[3:2] == 2'h3)
							begin
								half_nxt = sh_r[1];
								drv_nxt = 1'b1;
								fol_nxt = 1'b1;
							end
							else if (sh_r[0] && cb[2])
								drv_nxt = !prot_r[cb[1:0]];
							else if (sh_r[0] && sh_r[3:1] == `SEA_CODE_HALF0)
								drv_nxt = !half_r;
							else
								st_nxt = ST_IDLE;
						end
						else
							st_nxt = ST_IDLE;
					ST_ADDR:
					begin
						ptr_nxt = sh_r;
						drv_nxt = 1'b1;
						st_nxt = ST_WDATA;
					end
					ST_WDATA:
						if (!prot_r[wloc[8:7]] && push_rdy)
						begin
							push_v = 1'b1;
							push_d = '{loc: wloc, data: sh_r};
							drv_nxt = 1'b1;
							ptr_nxt = {ptr_r[7:4], ptr_r[3:0] + 4'h1};
							pend_nxt = OP_MEM;
						end
					ST_CMD:
						drv_nxt = fol_r;
					ST_RDATA:
						drv_nxt = 1'b0;
					default:
						st_nxt = ST_IDLE;
				endcase
			end
			else if (bit_r == `SEA_ACK_END)
			begin
				bit_nxt = 4'h0;
				drv_nxt = 1'b0;
				slot_nxt = st_r == ST_WDATA || st_r == ST_CMD;
				if (st_r == ST_RDATA)
				begin
					rbyte_nxt = mem[wloc];
					drv_nxt = !mem[wloc][7];
					ptr_nxt = ptr_r + 8'h01;
				end
			end
			else if (st_r == ST_RDATA)
			begin
				drv_nxt = !rbyte_r[6];
				rbyte_nxt = {rbyte_r[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_r <= ST_IDLE;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			rbyte_r <= 8'h00;
			ptr_r <= 8'h00;
			drv_r <= 1'b0;
			half_r <= 1'b0;
			slot_r <= 1'b0;
			fol_r <= 1'b0;
			pend_r <= OP_NONE;
			pblk_r <= 2'h0;
		end
		else
		begin
			st_r <= st_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			rbyte_r <= rbyte_nxt;
			ptr_r <= ptr_nxt;
			drv_r <= drv_nxt;
			half_r <= half_nxt;
			slot_r <= slot_nxt;
			fol_r <= fol_nxt;
			pend_r <= pend_nxt;
			pblk_r <= pblk_nxt;
		end
	end

	// Two-entry buffer between byte receiver and page latch
	sea_wr_t fbuf [0:1];
	logic [1:0] fcnt_r, fcnt_nxt;
	logic fwp_r, frp_r, pop;
	assign push_rdy = fcnt_r != 2'h2;
	assign pop = fcnt_r != 2'h0 && !prog_r;
	always_comb
	begin
		fcnt_nxt = fcnt_r + {1'b0, push_v} - {1'b0, pop};
	end
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			fcnt_r <= 2'h0;
			fwp_r <= 1'b0;
			frp_r <= 1'b0;
		end
		else
		begin
			fcnt_r <= fcnt_nxt;
			fwp_r <= fwp_r ^ push_v;
			frp_r <= frp_r ^ pop;
		end
		if (push_v)
			fbuf[fwp_r] <= push_d;
	end

	// Page latch and self-timed programming
	logic [15:0] pmask_r, pmask_nxt;
	logic [4:0] phi_r, phi_nxt;
	logic [17:0] tcnt_r, tcnt_nxt;
	logic done;
	sea_wr_t fo;
	assign fo = fbuf[frp_r];
	assign done = prog_r && tcnt_r == 18'(T_WRITE_CYC - 1);
	always_comb
	begin
		pmask_nxt = pmask_r;
		phi_nxt = phi_r;
		tcnt_nxt = tcnt_r;
		prog_nxt = prog_r;
		op_nxt = op_r;
		opblk_nxt = opblk_r;
		if (pop)
		begin
			pmask_nxt[fo.loc[3:0]] = 1'b1;
			phi_nxt = fo.loc[8:4];
		end
		if (arm && !prog_r)
		begin
			prog_nxt = 1'b1;
			tcnt_nxt = 18'h0;
			op_nxt = pend_r;
			opblk_nxt = pblk_r;
		end
		else if (done)
		begin
			prog_nxt = 1'b0;
			pmask_nxt = 16'h0;
			op_nxt = OP_NONE;
		end
		else if (prog_r)
			tcnt_nxt = tcnt_r + 18'h1;
		else if (drop)
			pmask_nxt = 16'h0;
	end
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pmask_r <= 16'h0;
			phi_r <= 5'h0;
			tcnt_r <= 18'h0;
			prog_r <= 1'b0;
			op_r <= OP_NONE;
			opblk_r <= 2'h0;
		end
		else
		begin
			pmask_r <= pmask_nxt;
			phi_r <= phi_nxt;
			tcnt_r <= tcnt_nxt;
			prog_r <= prog_nxt;
			op_r <= op_nxt;
			opblk_r <= opblk_nxt;
		end
		if (pop)
			pbuf[fo.loc[3:0]] <= fo.data;
		if (done && op_r == OP_MEM)
			for (int i = 0; i < 16; i++)
				if (pmask_r[i])
					mem[{phi_r, 4'(i)}] <= pbuf[i];
		if (done && op_r == OP_SET)
			prot_r[opblk_r] <= 1'b1;
		if (done && op_r == OP_CLR)
			prot_r <= 4'h0;
	end

	assign sda_out = 1'b0;
	assign sda_oe_n = !drv_r;
	assign prog_busy = prog_r;
	assign active_half_index = half_r;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	property p_busy_nack;
		prog_r && st_r == ST_SEL && ev_fall && bit_r == `SEA_ACK_BIT |=> !drv_r && st_r == ST_IDLE;
	endproperty
	a_busy_nack: assert property (p_busy_nack) else $error("select acked while busy");
	property p_prog_start;
		!prog_r ##1 prog_r |-> $past(ev_stop) && $past(slot_r);
	endproperty
	a_prog_start: assert property (p_prog_start) else $error("program start not on stop slot");
	property p_prot_write;
		ev_fall && bit_r == `SEA_ACK_BIT && st_r == ST_WDATA && prot_r[wloc[8:7]]
			|=> !drv_r && ptr_r == $past(ptr_r);
	endproperty
	a_prot_write: assert property (p_prot_write) else $error("protected byte acked");
	property p_free_write;
		ev_fall && bit_r == `SEA_ACK_BIT && st_r == ST_WDATA && !prot_r[wloc[8:7]] && push_rdy
			|=> drv_r && ptr_r[3:0] == $past(ptr_r[3:0]) + 4'h1;
	endproperty
	a_free_write: assert property (p_free_write) else $error("free byte not acked");
	property p_half_reset;
		srst |=> !active_half_index;
	endproperty
	a_half_reset: assert property (disable iff (1'b0) p_half_reset) else $error("half not cleared");
	property p_read_nack;
		st_r == ST_RDATA && ev_rise && bit_r == `SEA_ACK_BIT && s2_r.sda |=> st_r == ST_IDLE ##1 !drv_r;
	endproperty
	a_read_nack: assert property (p_read_nack) else $error("no idle after master nack");
	property p_clear;
		done && op_r == OP_CLR |=> prot_r == 4'h0 && !prog_r;
	endproperty
	a_clear: assert property (p_clear) else $error("clear left protection");
	property p_read_inc;
		st_r == ST_RDATA && ev_fall && bit_r == `SEA_ACK_END |=> ptr_r == $past(ptr_r) + 8'h01;
	endproperty
	a_read_inc: assert property (p_read_inc) else $error("read counter not advanced");
	property p_hv_needed;
		st_r == ST_SEL && !prog_r && ev_fall && bit_r == `SEA_ACK_BIT && sh_r[7:4] == `SEA_TYPE_CMD
			&& !sh_r[0] && !s2_r.hv && sh_r[3:2] != 2'h3 |=> !drv_r;
	endproperty
	a_hv_needed: assert property (p_hv_needed) else $error("set or clear acked without hv");
endmodule
`default_nettype wire

/* verification/sea_host_model.sv */
// Bus master model driving the two-wire lines of the EEPROM
`default_nettype none
module sea_host_model (
	// Clock
	input wire logic clk,
	// Bus lines
	input wire logic sda,
	output var logic scl,
	output var logic sda_low
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// One bus phase, held long enough for the pin filter
	task automatic ph(input logic c, input logic d);
		@(posedge clk);
		scl <= c;
		sda_low <= !d;
		repeat (6) @(posedge clk);
	endtask
	// Start or repeated start
	task automatic start();
		ph(1'b0, 1'b1);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
	endtask
	task automatic stop();
		ph(1'b0, 1'b0);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
	endtask
	// Byte MSB first, then ninth bit a9; returns bits seen and device ack
	task automatic xfer(input logic [7:0] d, input logic a9, output logic [7:0] r,
		output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			ph(1'b0, d[i]);
			ph(1'b1, d[i]);
			r[i] = sda;
		end
		ph(1'b0, a9);
		ph(1'b1, a9);
		ack = !sda;
	endtask
endmodule
`default_nettype wire

/* verification/sea_eeprom_bench.sv */
// Self-checking bench of the serial EEPROM access and protection block
`default_nettype none
module sea_eeprom_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import sea_pkg::*;
	localparam int TW = 200;
	logic clk;
	logic srst;
	logic hv;
	logic scl;
	logic sda_low;
	logic sda_out;
	logic sda_oe_n;
	logic prog_busy;
	logic half;
	logic ak;
	wire logic sda_w;
	sea_pins_t pins;
	int err_count = 0;
	int n_tests = 0;
	int cyc = 0;
	// Pull-up on the data line
	assign sda_w = !sda_low && (sda_oe_n || sda_out);
	assign pins = {scl, sda_w, hv, 3'h5};
	sea_eeprom #(.T_WRITE_CYC(TW)) i_sea_eeprom (.clk(clk), .srst(srst), .pins(pins),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .prog_busy(prog_busy),
		.active_half_index(half));
	sea_host_model i_sea_host_model (.clk(clk), .sda(sda_w), .scl(scl), .sda_low(sda_low));
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic end_sim();
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			err_count++;
			end_sim();
		end
	end
	task automatic chk_ack(input logic got, input logic exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t ack got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t byte got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic [7:0] d, output logic a);
		logic [7:0] r;
		i_sea_host_model.xfer(d, 1'b1, r, a);
	endtask
	task automatic sel(input logic [7:0] s, output logic a);
		i_sea_host_model.start();
		wb(s, a);
	endtask
	// Busy polling after a stop that should start programming
	task automatic poll();
		chk_ack(prog_busy, 1'b1);
		sel(8'haa, ak);
		chk_ack(ak, 1'b0);
		i_sea_host_model.stop();
		for (int i = 0; i < 20 && !ak; i++)
		begin
			sel(8'haa, ak);
			i_sea_host_model.stop();
		end
		chk_ack(ak, 1'b1);
	endtask
	// Three-byte command with expected acks, pg when a write cycle follows
	task automatic cmd(input logic [7:0] s, input logic [2:0] ea, input logic pg);
		sel(s, ak);
		chk_ack(ak, ea[2]);
		wb(8'h00, ak);
		chk_ack(ak, ea[1]);
		wb(8'h00, ak);
		chk_ack(ak, ea[0]);
		i_sea_host_model.stop();
		if (pg)
			poll();
		else
			chk_ack(prog_busy, 1'b0);
	endtask
	task automatic mem_wr(input logic [7:0] a, input int n, input logic [7:0] d0,
		input logic ea);
		sel(8'haa, ak);
		chk_ack(ak, 1'b1);
		wb(a, ak);
		chk_ack(ak, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			wb(d0 + 8'(i), ak);
			chk_ack(ak, ea);
		end
		i_sea_host_model.stop();
		if (ea)
			poll();
		else
			chk_ack(prog_busy, 1'b0);
	endtask
	// Random read when rnd, else current read; n bytes expected e0, e0+1, ...
	task automatic rd(input logic rnd, input logic [7:0] a, input int n, input logic [7:0] e0);
		logic [7:0] r;
		logic k;
		if (rnd)
		begin
			sel(8'haa, ak);
			wb(a, ak);
		end
		sel(8'hab, ak);
		chk_ack(ak, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			i_sea_host_model.xfer(8'hff, i == n - 1, r, k);
			chk_byte(r, e0 + 8'(i));
		end
		i_sea_host_model.stop();
	endtask
	initial
	begin
		srst = 1'b1;
		hv = 1'b0;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		repeat (5) @(posedge clk);
		chk_ack(half, 1'b0);
		mem_wr(8'h00, 1, 8'h11, 1'b1);
		mem_wr(8'hff, 1, 8'h10, 1'b1);
		mem_wr(8'h20, 4, 8'ha0, 1'b1);
		rd(1'b1, 8'hff, 2, 8'h10);
		rd(1'b1, 8'h20, 3, 8'ha0);
		rd(1'b0, 8'h00, 1, 8'ha3);
		sel(8'ha4, ak);
		chk_ack(ak, 1'b0);
		i_sea_host_model.stop();
		$display("test read write done");
		@(posedge clk);
		hv <= 1'b1;
		cmd(8'h62, 3'b111, 1'b1);
		cmd(8'h63, 3'b000, 1'b0);
		cmd(8'h69, 3'b100, 1'b0);
		cmd(8'h62, 3'b000, 1'b0);
		mem_wr(8'h00, 1, 8'h55, 1'b0);
		rd(1'b0, 8'h00, 1, 8'h11);
		@(posedge clk);
		hv <= 1'b0;
		cmd(8'h66, 3'b000, 1'b0);
		$display("test protection done");
		cmd(8'h6e, 3'b111, 1'b0);
		chk_ack(half, 1'b1);
		cmd(8'h6d, 3'b000, 1'b0);
		mem_wr(8'h00, 1, 8'h33, 1'b1);
		rd(1'b1, 8'h00, 1, 8'h33);
		@(posedge clk);
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		repeat (5) @(posedge clk);
		chk_ack(half, 1'b0);
		cmd(8'h6d, 3'b100, 1'b0);
		rd(1'b1, 8'h00, 1, 8'h11);
		cmd(8'h63, 3'b000, 1'b0);
		@(posedge clk);
		hv <= 1'b1;
		cmd(8'h66, 3'b111, 1'b1);
		cmd(8'h63, 3'b100, 1'b0);
		$display("test half select done");
		end_sim();
	end
endmodule
`default_nettype wire
